// File: hw/hpst_regs.v
`timescale 1ns/100ps
`include "hpst_defines.vh"

// strobe trim control and de-skew result register bank
module hpst_regs
(
  // clock, reset, enable
  input  wire         clk,
  input  wire         rst,
  input  wire         ce,
  // register port
  input  wire [7:0]   reg_addr,
  input  wire [7:0]   reg_wdata,
  input  wire         reg_wr,
  input  wire         reg_rd,
  output reg  [7:0]   reg_rdata,
  // strap preload, same clock
  input  wire         strap_load,
  input  wire [7:0]   strap_value,
  // de-skew trainer, foreign domain
  input  wire         deskew_rst_in,
  input  wire         deskew_started_in,
  input  wire [79:0]  deskew_result_in,
  // strobe clock controls to analog cells
  output wire         duty_corrector_bypass,
  output wire [1:0]   duty_trim_code,
  output wire [2:0]   clk_delay_code,
  // decoded trim figures
  output reg          duty_lengthen,
  output reg  [6:0]   duty_adjust_ps,
  output reg  [8:0]   clk_delay_ps,
  // nominal delay of address bundle group 0
  output reg  [8:0]   addr_g0_delay_ps,
  // trainer state seen by this block
  output wire         deskew_valid
);

  // control byte, only writable bits stored
  reg  [7:0]  trim_reg;
  reg  [7:0]  trim_next;

  // two-flop synchronisers for trainer signals
  reg         dsk_rst_s1_reg;
  reg         dsk_rst_s2_reg;
  reg         dsk_start_s1_reg;
  reg         dsk_start_s2_reg;
  reg  [79:0] dsk_res_s1_reg;
  reg  [79:0] dsk_res_s2_reg;

  // third result stage and the coherent copy software reads
  reg  [79:0] dsk_res_s3_reg;
  reg  [79:0] dsk_res_hold_reg;
  wire        dsk_res_steady;

  // a coherent word is held while the trainer is up
  reg         view_ok_reg;
  wire        view_ok;

  // results as software sees them
  wire [79:0] result_view;

  // read path helpers
  reg  [7:0]  rd_next;
  wire [7:0]  res_idx;
  wire [2:0]  res_bundle;
  wire        res_odd;
  wire        in_result;
  wire        in_rsv0;
  wire        in_rsv1;

  // decoded next values
  reg         lengthen_next;
  reg  [6:0]  adjust_next;
  reg  [8:0]  delay_next;
  reg  [8:0]  g0_delay_next;

  // write hits the control byte
  wire        trim_hit;

  assign trim_hit = reg_wr && (reg_addr == `HPST_OFF_STROBE_TRIM);

  // reserved ranges decode, kept only for the read mux
  assign in_rsv0 = (reg_addr >= `HPST_OFF_RSV0_LO) &&
                   (reg_addr <= `HPST_OFF_RSV0_HI);
  assign in_rsv1 = (reg_addr >= `HPST_OFF_RSV1_LO);

  // result window d0..d9
  assign in_result = (reg_addr >= `HPST_OFF_DLANE0_G01) &&
                     (reg_addr <= `HPST_OFF_ADDR_G23);
  assign res_idx    = reg_addr - `HPST_OFF_DLANE0_G01;
  assign res_bundle = res_idx[3:1];
  assign res_odd    = res_idx[0];

  // trainer has run and is out of reset
  assign deskew_valid = dsk_start_s2_reg && !dsk_rst_s2_reg;

  // results shown only once a coherent word is held
  assign view_ok = deskew_valid && view_ok_reg;

  // control fields straight from the stored byte
  assign duty_corrector_bypass = trim_reg[`HPST_BYPASS_BIT];
  assign duty_trim_code        = trim_reg[`HPST_DUTY_HI:`HPST_DUTY_LO];
  assign clk_delay_code        = trim_reg[`HPST_DELAY_HI:`HPST_DELAY_LO];

  // per-bundle default masking while untrained
  genvar b;
  generate
    for (b = 0; b < `HPST_BUNDLES; b = b + 1)
    begin : g_bundle
      // group 0 of each even byte
      assign result_view[16*b+3:16*b] = view_ok ?
        dsk_res_hold_reg[16*b+3:16*b] : `HPST_G0_DEFAULT;
      // group 1 of each even byte
      assign result_view[16*b+7:16*b+4] = view_ok ?
        dsk_res_hold_reg[16*b+7:16*b+4] : `HPST_GX_DEFAULT;
      // groups 2 and 3 in the odd byte
      assign result_view[16*b+11:16*b+8] = view_ok ?
        dsk_res_hold_reg[16*b+11:16*b+8] : `HPST_GX_DEFAULT;
      assign result_view[16*b+15:16*b+12] = view_ok ?
        dsk_res_hold_reg[16*b+15:16*b+12] : `HPST_GX_DEFAULT;
    end
  endgenerate

  // control byte next value
  // a software write beats a strap load in the same cycle,
  // since software acts on purpose and the strap only once
  always @*
  begin
    trim_next = trim_reg;
    if (trim_hit)
    begin
      // reserved bits 6 and 3 dropped on write
      trim_next = reg_wdata & `HPST_TRIM_WR_MASK;
    end
    else if (strap_load)
    begin
      // strap preload masked the same way
      trim_next = strap_value & `HPST_TRIM_WR_MASK;
    end
  end

  // control byte storage
  always @(posedge clk)
  begin
    if (rst)
    begin
      // bypass on, both trims zero
      trim_reg <= `HPST_STROBE_TRIM_RST;
    end
    else if (ce)
    begin
      trim_reg <= trim_next;
    end
  end

  // synchronisers: stage one read only by stage two
  // each result bit is synchronised on its own here;
  // the filter below makes the word as a whole coherent
  always @(posedge clk)
  begin
    if (rst)
    begin
      dsk_rst_s1_reg   <= 1'b1;
      dsk_rst_s2_reg   <= 1'b1;
      dsk_start_s1_reg <= 1'b0;
      dsk_start_s2_reg <= 1'b0;
      dsk_res_s1_reg   <= {`HPST_RESULT_W{1'b0}};
      dsk_res_s2_reg   <= {`HPST_RESULT_W{1'b0}};
    end
    else if (ce)
    begin
      dsk_rst_s1_reg   <= deskew_rst_in;
      dsk_rst_s2_reg   <= dsk_rst_s1_reg;
      dsk_start_s1_reg <= deskew_started_in;
      dsk_start_s2_reg <= dsk_start_s1_reg;
      dsk_res_s1_reg   <= deskew_result_in;
      dsk_res_s2_reg   <= dsk_res_s1_reg;
    end
  end

  // word crossing: the 80 result bits come from a foreign clock and
  // may be caught mid-change, so a word is taken only when two
  // successive synchronised samples agree; costs two cycles of latency
  assign dsk_res_steady = (dsk_res_s2_reg == dsk_res_s3_reg);

  // result filter: stage three and the held word
  always @(posedge clk)
  begin
    if (rst)
    begin
      // nothing trained yet; masking hides these anyway
      dsk_res_s3_reg   <= {`HPST_RESULT_W{1'b0}};
      dsk_res_hold_reg <= {`HPST_RESULT_W{1'b0}};
    end
    else if (ce)
    begin
      // stage three only ever reads stage two
      dsk_res_s3_reg <= dsk_res_s2_reg;
      if (dsk_res_steady)
      begin
        // two equal samples: the word is coherent
        dsk_res_hold_reg <= dsk_res_s2_reg;
      end
      else
      begin
        // still moving: keep the last coherent word
        dsk_res_hold_reg <= dsk_res_hold_reg;
      end
    end
  end

  // view qualifier: raised once a coherent word is held while the
  // trainer is up, dropped as soon as the trainer goes away
  always @(posedge clk)
  begin
    if (rst)
    begin
      // untrained after reset
      view_ok_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (!deskew_valid)
      begin
        // trainer in reset or not started
        view_ok_reg <= 1'b0;
      end
      else if (dsk_res_steady)
      begin
        // hold takes a coherent word at this same edge
        view_ok_reg <= 1'b1;
      end
    end
  end

  // read data mux, zero when no read so data stand one cycle
  always @*
  begin
    rd_next = 8'h00;
    if (reg_rd)
    begin
      if (reg_addr == `HPST_OFF_STROBE_TRIM)
      begin
        // reserved bits already zero in storage
        rd_next = trim_reg;
      end
      else if (in_result)
      begin
        // even byte groups 0/1, odd byte groups 2/3
        case (res_bundle)
          3'h0:    rd_next = res_odd ? result_view[15:8]  : result_view[7:0];
          3'h1:    rd_next = res_odd ? result_view[31:24] : result_view[23:16];
          3'h2:    rd_next = res_odd ? result_view[47:40] : result_view[39:32];
          3'h3:    rd_next = res_odd ? result_view[63:56] : result_view[55:48];
          3'h4:    rd_next = res_odd ? result_view[79:72] : result_view[71:64];
          default: rd_next = 8'h00;
        endcase
      end
      else if (in_rsv0 || in_rsv1)
      begin
        // reserved space reads zero
        rd_next = 8'h00;
      end
      else
      begin
        // unmapped offsets read zero too
        rd_next = 8'h00;
      end
    end
  end

  // read data register
  // writes to result offsets fall through: nothing stores them
  always @(posedge clk)
  begin
    if (rst)
    begin
      reg_rdata <= 8'h00;
    end
    else if (ce)
    begin
      reg_rdata <= rd_next;
    end
  end

  // duty trim decode
  always @*
  begin
    lengthen_next = 1'b1;
    adjust_next   = `HPST_DUTY_FINE_PS;
    case (duty_trim_code)
      `HPST_DUTY_LONG_40:
      begin
        lengthen_next = 1'b1;
        adjust_next   = `HPST_DUTY_FINE_PS;
      end
      `HPST_DUTY_LONG_80:
      begin
        lengthen_next = 1'b1;
        adjust_next   = `HPST_DUTY_COARSE_PS;
      end
      `HPST_DUTY_SHORT_40:
      begin
        lengthen_next = 1'b0;
        adjust_next   = `HPST_DUTY_FINE_PS;
      end
      `HPST_DUTY_SHORT_80:
      begin
        lengthen_next = 1'b0;
        adjust_next   = `HPST_DUTY_COARSE_PS;
      end
      default:
      begin
        lengthen_next = 1'b1;
        adjust_next   = `HPST_DUTY_FINE_PS;
      end
    endcase
  end

  // delay decode: code zero still gives one step
  always @*
  begin
    delay_next = ({6'h00, clk_delay_code} + 9'h001) * `HPST_DELAY_STEP_PS;
  end

  // nominal address group 0 delay; true step may be 20 to 39 ps
  always @*
  begin
    g0_delay_next = {5'h00, result_view[67:64]} * `HPST_DESKEW_STEP_PS;
  end

  // decoded figures held in flops
  always @(posedge clk)
  begin
    if (rst)
    begin
      // matches the reset control byte
      duty_lengthen    <= 1'b1;
      duty_adjust_ps   <= `HPST_DUTY_FINE_PS;
      clk_delay_ps     <= `HPST_DELAY_STEP_PS;
      addr_g0_delay_ps <= {5'h00, `HPST_G0_DEFAULT} * `HPST_DESKEW_STEP_PS;
    end
    else if (ce)
    begin
      duty_lengthen    <= lengthen_next;
      duty_adjust_ps   <= adjust_next;
      clk_delay_ps     <= delay_next;
      addr_g0_delay_ps <= g0_delay_next;
    end
  end

endmodule

// File: hw/hpst_defines.vh
// Contract
// - bit 7 selects duty corrector bypass
// - control byte resets to 80h
// - bits 5:4 lengthen or shorten high phase
// - bits 2:0 give (n+1) times 60ps delay
// - CA-CF and DA-FF reserved, no function
// - result fields read-only 4-bit step counts
// - nominal de-skew step is 29ps
// - group 0 reads 0111b until training
// - group 1 reads 0000b until training
// - odd byte holds groups 2 and 3
// - D0-D7 pairs cover four data bundles
// - D8/D9 pair covers address and request lanes
`ifndef HPST_DEFINES_VH
`define HPST_DEFINES_VH

// register offsets, byte addressed
`define HPST_OFF_STROBE_TRIM   8'hc9
`define HPST_OFF_DLANE0_G01    8'hd0
`define HPST_OFF_DLANE0_G23    8'hd1
`define HPST_OFF_DLANE1_G01    8'hd2
`define HPST_OFF_DLANE1_G23    8'hd3
`define HPST_OFF_DLANE2_G01    8'hd4
`define HPST_OFF_DLANE2_G23    8'hd5
`define HPST_OFF_DLANE3_G01    8'hd6
`define HPST_OFF_DLANE3_G23    8'hd7
`define HPST_OFF_ADDR_G01      8'hd8
`define HPST_OFF_ADDR_G23      8'hd9
`define HPST_OFF_RSV0_LO       8'hca
`define HPST_OFF_RSV0_HI       8'hcf
`define HPST_OFF_RSV1_LO       8'hda
`define HPST_OFF_RSV1_HI       8'hff

// control byte layout and reset
`define HPST_STROBE_TRIM_RST   8'h80
`define HPST_TRIM_WR_MASK      8'hb7
`define HPST_BYPASS_BIT        7
`define HPST_DUTY_HI           5
`define HPST_DUTY_LO           4
`define HPST_DELAY_HI          2
`define HPST_DELAY_LO          0

// duty trim encodings
`define HPST_DUTY_LONG_40      2'h0
`define HPST_DUTY_LONG_80      2'h1
`define HPST_DUTY_SHORT_40     2'h2
`define HPST_DUTY_SHORT_80     2'h3
`define HPST_DUTY_FINE_PS      7'h28
`define HPST_DUTY_COARSE_PS    7'h50

// strobe delay step, 60 ps
`define HPST_DELAY_STEP_PS     9'h03c

// de-skew step sizes: 29 ps nominal, 20 to 39 ps
`define HPST_DESKEW_STEP_PS    9'h01d
`define HPST_DESKEW_MIN_PS     9'h014
`define HPST_DESKEW_MAX_PS     9'h027

// result defaults while untrained
`define HPST_G0_DEFAULT        4'h7
`define HPST_GX_DEFAULT        4'h0
`define HPST_BUNDLES           5
`define HPST_RESULT_W          80

`endif

// File: tb/hpst_sva.sv
`timescale 1ns/100ps
// watches the register port and the decoded trim outputs
module hpst_sva
(
  // clock and enables
  input logic       clk,
  input logic       rst,
  input logic       ce,
  // register port
  input logic [7:0] reg_addr,
  input logic       reg_wr,
  input logic       reg_rd,
  input logic [7:0] reg_rdata,
  input logic       strap_load,
  // trim and trainer outputs
  input logic       duty_corrector_bypass,
  input logic [1:0] duty_trim_code,
  input logic [2:0] clk_delay_code,
  input logic       duty_lengthen,
  input logic [6:0] duty_adjust_ps,
  input logic [8:0] clk_delay_ps,
  input logic       deskew_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // read accepted at this edge
  wire rd_go = reg_rd && ce;
  // reserved offsets
  wire rsv = (reg_addr >= 8'hca && reg_addr <= 8'hcf) || reg_addr >= 8'hda;
  // result bytes d0..d9
  wire res = reg_addr >= 8'hd0 && reg_addr <= 8'hd9;
  a_reset_value: assert property (
    $fell(rst) |-> duty_corrector_bypass && duty_trim_code == 2'h0 && clk_delay_code == 3'h0)
    else $error("control not at reset value");
  a_ctrl_readback: assert property (
    rd_go && reg_addr == 8'hc9 |=> reg_rdata ==
      $past({duty_corrector_bypass, 1'b0, duty_trim_code, 1'b0, clk_delay_code}))
    else $error("control readback mismatch");
  a_rsvd_zero: assert property (rd_go && rsv |=> reg_rdata == 8'h00)
    else $error("reserved read not zero");
  a_untrained_even: assert property (
    rd_go && res && !reg_addr[0] && !deskew_valid |=> reg_rdata == 8'h07)
    else $error("untrained even byte wrong");
  a_untrained_odd: assert property (
    rd_go && res && reg_addr[0] && !deskew_valid |=> reg_rdata == 8'h00)
    else $error("untrained odd byte wrong");
  a_delay_decode: assert property (
    ce |=> clk_delay_ps == ({6'h00, $past(clk_delay_code)} + 9'h001) * 9'h03c)
    else $error("delay figure wrong");
  a_duty_decode: assert property (
    ce |=> duty_lengthen == !$past(duty_trim_code[1])
      && duty_adjust_ps == ($past(duty_trim_code[0]) ? 7'h50 : 7'h28))
    else $error("duty figure wrong");
  a_ro_no_effect: assert property (
    reg_wr && ce && reg_addr != 8'hc9 && !strap_load
      |=> $stable({duty_corrector_bypass, duty_trim_code, clk_delay_code}))
    else $error("write elsewhere changed control");
  c_ctrl_write: cover property (reg_wr && ce && reg_addr == 8'hc9);
  c_trained_read: cover property (rd_go && res && deskew_valid);
  c_rsvd_read: cover property (rd_go && rsv);
endmodule

bind hpst_regs hpst_sva chk_u (.clk, .rst, .ce, .reg_addr, .reg_wr, .reg_rd, .reg_rdata,
  .strap_load, .duty_corrector_bypass, .duty_trim_code, .clk_delay_code, .duty_lengthen,
  .duty_adjust_ps, .clk_delay_ps, .deskew_valid);

// File: tb/hpst_trainer_model.sv
`timescale 1ns/100ps
// de-skew trainer stand-in
module hpst_trainer_model
(
  // clock and bench command
  input  logic        clk,
  input  logic        train_go,
  input  logic [79:0] train_value,
  // toward the register bank
  output logic        deskew_rst_in,
  output logic        deskew_started_in,
  output logic [79:0] deskew_result_in
);
  initial
  begin
    deskew_rst_in     = 1'b1;
    deskew_started_in = 1'b0;
    deskew_result_in  = 80'h0;
  end
  // untrained results churn so stale data cannot pass for defaults
  always @(posedge clk)
  begin
    deskew_rst_in     <= !train_go;
    deskew_started_in <= train_go;
    deskew_result_in  <= train_go ? train_value : ~deskew_result_in;
  end
endmodule

// File: tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic        clk, rst, ce, reg_wr, reg_rd, strap_load, train_go;
  logic [7:0]  reg_addr, reg_wdata, strap_value;
  logic [79:0] tv;
  wire  [7:0]  reg_rdata;
  wire         d_rst, d_go, bypass, lengthen, dvalid;
  wire  [79:0] d_res;
  wire  [1:0]  duty_code;
  wire  [2:0]  dly_code;
  wire  [6:0]  adj_ps;
  wire  [8:0]  dly_ps, g0_ps;
  int          miscompares, samples_checked, cycles;

  hpst_regs dut_u (.clk, .rst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .strap_load, .strap_value, .deskew_rst_in(d_rst), .deskew_started_in(d_go),
    .deskew_result_in(d_res), .duty_corrector_bypass(bypass), .duty_trim_code(duty_code),
    .clk_delay_code(dly_code), .duty_lengthen(lengthen), .duty_adjust_ps(adj_ps),
    .clk_delay_ps(dly_ps), .addr_g0_delay_ps(g0_ps), .deskew_valid(dvalid));
  hpst_trainer_model trn_u (.clk, .train_go, .train_value(tv),
    .deskew_rst_in(d_rst), .deskew_started_in(d_go), .deskew_result_in(d_res));

  // 20 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // hang guard, run needs under 150 cycles
  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (cycles == 3000)
    begin
      miscompares++;
      complete_run();
    end
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check("reg_rdata", reg_rdata, exp);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    logic [7:0] wd;
    logic [7:0] rsv_a [6];
    rst = 1'b1; ce = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; strap_load = 1'b0;
    train_go = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00; strap_value = 8'h00;
    tv = 80'hfedcba9876543210a5c3;
    miscompares = 0; samples_checked = 0; cycles = 0;
    rsv_a = '{8'hca, 8'hcf, 8'hda, 8'hff, 8'h00, 8'hc8};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(8'hc9, 8'h80);
    for (int i = 0; i < 10; i++) rd(8'hd0 + i[7:0], i[0] ? 8'h00 : 8'h07);
    check("clk_delay_ps", dly_ps, 16'h003c);
    check("bypass", bypass, 16'h0001);
    $display("reset test done");
    // every duty and delay code, reserved bits always set
    for (int k = 0; k < 8; k++)
    begin
      wd = {k[2], 1'b1, k[1:0], 1'b1, k[2:0]};
      wr(8'hc9, wd);
      rd(8'hc9, wd & 8'hb7);
      check("bypass", bypass, k[2]);
      check("duty_trim_code", duty_code, k[1:0]);
      check("clk_delay_code", dly_code, k[2:0]);
      check("lengthen", lengthen, !k[1]);
      check("duty_adjust_ps", adj_ps, k[0] ? 16'h0050 : 16'h0028);
      check("clk_delay_ps", dly_ps, 16'((k + 1) * 60));
    end
    $display("trim test done");
    foreach (rsv_a[j])
    begin
      wr(rsv_a[j], 8'h5a);
      rd(rsv_a[j], 8'h00);
    end
    wr(8'hd0, 8'h00);
    rd(8'hd0, 8'h07);
    // enable low: the write must not land
    @(posedge clk);
    ce <= 1'b0;
    wr(8'hc9, 8'h00);
    ce <= 1'b1;
    rd(8'hc9, 8'hb7);
    @(posedge clk);
    strap_load <= 1'b1;
    strap_value <= 8'h4a;
    @(posedge clk);
    strap_load <= 1'b0;
    rd(8'hc9, 8'h02);
    $display("access test done");
    @(posedge clk);
    train_go <= 1'b1;
    repeat (6) @(posedge clk);
    for (int i = 0; i < 10; i++) rd(8'hd0 + i[7:0], tv[8*i +: 8]);
    check("deskew_valid", dvalid, 16'h0001);
    check("addr_g0_delay_ps", g0_ps, 16'(tv[67:64]) * 16'h001d);
    wr(8'hd4, 8'h00);
    rd(8'hd4, tv[39:32]);
    @(posedge clk);
    train_go <= 1'b0;
    repeat (4) @(posedge clk);
    rd(8'hd8, 8'h07);
    rd(8'hd9, 8'h00);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    rd(8'hc9, 8'h80);
    $display("training test done");
    complete_run();
  end
endmodule
